/* logic/pswr_cfg.svh */
// offsets, field positions, reset values and figures of the pwm / wake register bank
`ifndef PSWR_CFG_SVH
`define PSWR_CFG_SVH
`define PSWR_ADDR_W 7
`define PSWR_OFF_PWM_FREQ 7'h1c
`define PSWR_OFF_SCRATCH 7'h1e
`define PSWR_OFF_WAKE_CTRL 7'h20
`define PSWR_OFF_QUANTA 7'h21
`define PSWR_OFF_SAMPLE 7'h22
`define PSWR_OFF_IDENT_HI 7'h23
`define PSWR_OFF_LP_OPT 7'h30
`define PSWR_OFF_IRQ_STAT 7'h31
`define PSWR_OFF_IRQ_MASK 7'h32
`define PSWR_OFF_MODE 7'h33
`define PSWR_BIT_CHAN_TWO 2
`define PSWR_BIT_CHAN_ONE 0
`define PSWR_BIT_TRIM_MODE 7
`define PSWR_BIT_TO_ALLOW 4
`define PSWR_BIT_SETUP_VALID 0
`define PSWR_PWM_FREQ_MASK 8'h05
`define PSWR_WAKE_CTRL_MASK 8'hf1
`define PSWR_WAKE_RESTART_KEEP 8'hf0
`define PSWR_SAMPLE_MASK 8'h3f
`define PSWR_UNLOCK_CODE 2'h3
`define PSWR_RST_PWM_FREQ 8'h00
`define PSWR_RST_SCRATCH 8'h00
`define PSWR_RST_WAKE_CTRL 8'h00
`define PSWR_RST_QUANTA 8'ha0
`define PSWR_RST_SAMPLE 8'h33
`define PSWR_RST_IDENT_HI 8'h00
`define PSWR_RATE_LOW_HZ 200
`define PSWR_RATE_HIGH_HZ 400
`endif

/* logic/pswr_pkg.sv */
// types of the pwm / wake register bank
`default_nettype none
package pswr_pkg;
  typedef enum logic [2:0] {
    PSWR_MODE_INIT = 3'b000,
    PSWR_MODE_NORMAL = 3'b001,
    PSWR_MODE_STOP = 3'b010,
    PSWR_MODE_SLEEP = 3'b011,
    PSWR_MODE_RESTART = 3'b100,
    PSWR_MODE_FAILSAFE = 3'b101
  } pswr_mode_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pswr_req_t;
  typedef struct packed {
    logic trim_mode;
    logic [1:0] unlock;
    logic to_allow;
    logic setup_valid;
  } pswr_wake_t;
endpackage
`default_nettype wire

/* logic/pswr_regs.sv */
// pwm frequency, host scratch byte and selective wake configuration registers
//
// The plain strobed port was chosen for this implementation.
`include "pswr_cfg.svh"
`default_nettype none
module pswr_regs
  import pswr_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic soft_rst,
  input wire logic restart_entry,
  input wire pswr_mode_t chip_mode,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic bus_transmit_input_pin,
  input wire logic bus_timeout_event,
  input wire logic wake_frame_seen,
  input wire logic [28:0] rx_ident,
  input wire logic rx_ident_valid,
  output logic [7:0] rdata,
  output logic irq,
  output logic chan_one_rate_select,
  output logic chan_two_rate_select,
  output logic selective_wakeup_en,
  output logic oscillator_trim_mode,
  output logic trim_reference,
  output logic low_power_receiver_en,
  output logic [7:0] quanta_per_bit,
  output logic [5:0] sample_point_fraction,
  output logic ident_high_match
);
  pswr_req_t req;
  pswr_wake_t wk;
  logic [7:0] pwm_q, scratch_q, wctl_q, quanta_q, sample_q, ident_q, opt_q;
  logic [1:0] stat_q, mask_q;
  logic unlocked;
  logic normal;
  logic cfg_write;
  logic [7:0] rdata_d;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    return a == off;
  endfunction

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign wk = '{trim_mode: wctl_q[`PSWR_BIT_TRIM_MODE], unlock: wctl_q[6:5],
                to_allow: wctl_q[`PSWR_BIT_TO_ALLOW],
                setup_valid: wctl_q[`PSWR_BIT_SETUP_VALID]};
  assign unlocked = wk.unlock == `PSWR_UNLOCK_CODE;
  assign normal = chip_mode == PSWR_MODE_NORMAL;
  // any write of wake setup data, or a control write that changes bits 7:4 or clears valid
  assign cfg_write = req.wr && (hit(req.addr, `PSWR_OFF_QUANTA) ||
    hit(req.addr, `PSWR_OFF_SAMPLE) || hit(req.addr, `PSWR_OFF_IDENT_HI) ||
    (hit(req.addr, `PSWR_OFF_WAKE_CTRL) &&
     ((req.wdata[7:4] != wctl_q[7:4]) || !req.wdata[0])));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwm_q <= `PSWR_RST_PWM_FREQ;
    end else if (soft_rst) begin
      pwm_q <= `PSWR_RST_PWM_FREQ;
    end else if (restart_entry) begin
      pwm_q <= pwm_q & `PSWR_PWM_FREQ_MASK;
    end else if (req.wr && hit(req.addr, `PSWR_OFF_PWM_FREQ)) begin
      pwm_q <= req.wdata & `PSWR_PWM_FREQ_MASK;
    end
  end

  // only power-on clears it; soft reset, restart, fail-safe do not
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scratch_q <= `PSWR_RST_SCRATCH;
    end else if (req.wr && normal && hit(req.addr, `PSWR_OFF_SCRATCH)) begin
      scratch_q <= req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wctl_q <= `PSWR_RST_WAKE_CTRL;
    end else if (soft_rst) begin
      wctl_q <= `PSWR_RST_WAKE_CTRL;
    end else if (restart_entry) begin
      wctl_q <= wctl_q & `PSWR_WAKE_RESTART_KEEP;
    end else if (req.wr && hit(req.addr, `PSWR_OFF_WAKE_CTRL)) begin
      wctl_q <= req.wdata & `PSWR_WAKE_CTRL_MASK;
      // a wake frame in the same cycle beats a host re-validation
      if (req.wdata[7:4] != wctl_q[7:4] || wake_frame_seen) begin
        wctl_q[`PSWR_BIT_SETUP_VALID] <= 1'b0;
      end
    end else if (wake_frame_seen || cfg_write) begin
      wctl_q[`PSWR_BIT_SETUP_VALID] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      quanta_q <= `PSWR_RST_QUANTA;
      sample_q <= `PSWR_RST_SAMPLE;
      ident_q <= `PSWR_RST_IDENT_HI;
    end else if (soft_rst) begin
      quanta_q <= `PSWR_RST_QUANTA;
      sample_q <= `PSWR_RST_SAMPLE;
      ident_q <= `PSWR_RST_IDENT_HI;
    end else if (req.wr) begin
      if (hit(req.addr, `PSWR_OFF_QUANTA)) begin
        quanta_q <= req.wdata;
      end
      if (hit(req.addr, `PSWR_OFF_SAMPLE)) begin
        sample_q <= req.wdata & `PSWR_SAMPLE_MASK;
      end
      if (hit(req.addr, `PSWR_OFF_IDENT_HI)) begin
        ident_q <= req.wdata;
      end
    end
  end

  // option register is locked unless the unlock code stands
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      opt_q <= 8'h00;
    end else if (soft_rst) begin
      opt_q <= 8'h00;
    end else if (req.wr && unlocked && hit(req.addr, `PSWR_OFF_LP_OPT)) begin
      opt_q <= {7'h00, req.wdata[0]};
    end
  end

  // status bit0 bus timeout, bit1 wake frame; set beats read-clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= ((req.rd && hit(req.addr, `PSWR_OFF_IRQ_STAT)) ? 2'h0 : stat_q) |
                {wake_frame_seen, bus_timeout_event && selective_wakeup_en};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= 2'h0;
    end else if (req.wr && hit(req.addr, `PSWR_OFF_IRQ_MASK)) begin
      mask_q <= req.wdata[1:0];
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    unique case (req.addr)
      `PSWR_OFF_PWM_FREQ: rdata_d = pwm_q;
      `PSWR_OFF_SCRATCH: rdata_d = normal ? scratch_q : 8'h00;
      `PSWR_OFF_WAKE_CTRL: rdata_d = wctl_q;
      `PSWR_OFF_QUANTA: rdata_d = quanta_q;
      `PSWR_OFF_SAMPLE: rdata_d = sample_q;
      `PSWR_OFF_IDENT_HI: rdata_d = ident_q;
      `PSWR_OFF_LP_OPT: rdata_d = opt_q;
      `PSWR_OFF_IRQ_STAT: rdata_d = {6'h00, stat_q};
      `PSWR_OFF_IRQ_MASK: rdata_d = {6'h00, mask_q};
      `PSWR_OFF_MODE: rdata_d = {5'h00, chip_mode};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= req.rd ? rdata_d : 8'h00;
    end
  end

  // timeout interrupt also needs the per-bit allow in the control register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q & {1'b1, wk.to_allow});
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chan_one_rate_select <= 1'b0;
      chan_two_rate_select <= 1'b0;
      selective_wakeup_en <= 1'b0;
      oscillator_trim_mode <= 1'b0;
      trim_reference <= 1'b0;
      low_power_receiver_en <= 1'b0;
      quanta_per_bit <= `PSWR_RST_QUANTA;
      sample_point_fraction <= 6'h33;
      ident_high_match <= 1'b0;
    end else begin
      chan_one_rate_select <= pwm_q[`PSWR_BIT_CHAN_ONE];
      chan_two_rate_select <= pwm_q[`PSWR_BIT_CHAN_TWO];
      selective_wakeup_en <= wk.setup_valid && !wake_frame_seen;
      oscillator_trim_mode <= wk.trim_mode;
      trim_reference <= wk.trim_mode && unlocked && bus_transmit_input_pin;
      low_power_receiver_en <= opt_q[0];
      quanta_per_bit <= quanta_q;
      sample_point_fraction <= sample_q[5:0];
      ident_high_match <= rx_ident_valid && rx_ident[28:21] == ident_q;
    end
  end

  property p_scratch_locked;
    @(posedge mclk) disable iff (!rstn)
      (wr && !normal && hit(addr, `PSWR_OFF_SCRATCH)) |=> $stable(scratch_q);
  endproperty
  a_scratch_locked: assert property (p_scratch_locked) else $error("scratch written");

  property p_scratch_soft;
    @(posedge mclk) disable iff (!rstn)
      (soft_rst && !wr) |=> $stable(scratch_q);
  endproperty
  a_scratch_soft: assert property (p_scratch_soft) else $error("scratch lost");

  property p_reserved_zero;
    @(posedge mclk) disable iff (!rstn)
      (rd && hit(addr, `PSWR_OFF_PWM_FREQ)) |=> (rdata & 8'hfa) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");

  property p_restart_nibble;
    @(posedge mclk) disable iff (!rstn)
      (restart_entry && !soft_rst) |=> wctl_q[3:0] == 4'h0 && wctl_q[7:4] == $past(wctl_q[7:4]);
  endproperty
  a_restart_nibble: assert property (p_restart_nibble) else $error("restart nibble");

  property p_opt_locked;
    @(posedge mclk) disable iff (!rstn)
      (!unlocked && !soft_rst) |=> $stable(opt_q);
  endproperty
  a_opt_locked: assert property (p_opt_locked) else $error("option written");

  property p_valid_drop;
    @(posedge mclk) disable iff (!rstn)
      (wake_frame_seen && !wr) |=> !wctl_q[0] ##1 !selective_wakeup_en;
  endproperty
  a_valid_drop: assert property (p_valid_drop) else $error("valid kept");

  property p_to_gate;
    @(posedge mclk) disable iff (!rstn)
      (!selective_wakeup_en && !(rd && hit(addr, `PSWR_OFF_IRQ_STAT)))
        |=> stat_q[0] == $past(stat_q[0]);
  endproperty
  a_to_gate: assert property (p_to_gate) else $error("timeout flag moved");

  property p_irq_mask;
    @(posedge mclk) disable iff (!rstn)
      (!wk.to_allow && !stat_q[1]) |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq");

  property p_rate;
    @(posedge mclk) disable iff (!rstn)
      (wr && hit(addr, `PSWR_OFF_PWM_FREQ) && !soft_rst && !restart_entry)
        |=> ##1 chan_two_rate_select == $past(wdata[`PSWR_BIT_CHAN_TWO], 2);
  endproperty
  a_rate: assert property (p_rate) else $error("rate select");

  property p_chan_one;
    @(posedge mclk) disable iff (!rstn)
      (wr && hit(addr, `PSWR_OFF_PWM_FREQ) && !soft_rst && !restart_entry)
        |=> ##1 chan_one_rate_select == $past(wdata[`PSWR_BIT_CHAN_ONE], 2);
  endproperty
  a_chan_one: assert property (p_chan_one) else $error("rate one select");

  property p_pwm_write;
    @(posedge mclk) disable iff (!rstn)
      (wr && hit(addr, `PSWR_OFF_PWM_FREQ) && !soft_rst && !restart_entry)
        |=> pwm_q == ($past(wdata) & `PSWR_PWM_FREQ_MASK);
  endproperty
  a_pwm_write: assert property (p_pwm_write) else $error("pwm write");

  property p_soft_clear;
    @(posedge mclk) disable iff (!rstn)
      soft_rst |=> pwm_q == `PSWR_RST_PWM_FREQ && wctl_q == `PSWR_RST_WAKE_CTRL &&
        quanta_q == `PSWR_RST_QUANTA && sample_q == `PSWR_RST_SAMPLE;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset values");

  property p_quanta_write;
    @(posedge mclk) disable iff (!rstn)
      (wr && hit(addr, `PSWR_OFF_QUANTA) && !soft_rst) |=> quanta_q == $past(wdata);
  endproperty
  a_quanta_write: assert property (p_quanta_write) else $error("quanta write");

  property p_sample_write;
    @(posedge mclk) disable iff (!rstn)
      (wr && hit(addr, `PSWR_OFF_SAMPLE) && !soft_rst)
        |=> sample_q == ($past(wdata) & `PSWR_SAMPLE_MASK);
  endproperty
  a_sample_write: assert property (p_sample_write) else $error("sample write");

  property p_ident_write;
    @(posedge mclk) disable iff (!rstn)
      (wr && hit(addr, `PSWR_OFF_IDENT_HI) && !soft_rst) |=> ident_q == $past(wdata);
  endproperty
  a_ident_write: assert property (p_ident_write) else $error("ident write");

  property p_cfg_change;
    @(posedge mclk) disable iff (!rstn)
      (wr && (hit(addr, `PSWR_OFF_QUANTA) || hit(addr, `PSWR_OFF_SAMPLE) ||
        hit(addr, `PSWR_OFF_IDENT_HI))) |=> !wctl_q[`PSWR_BIT_SETUP_VALID];
  endproperty
  a_cfg_change: assert property (p_cfg_change) else $error("valid kept on setup");

  property p_ctrl_nibble;
    @(posedge mclk) disable iff (!rstn)
      (wr && hit(addr, `PSWR_OFF_WAKE_CTRL) && wdata[7:4] != wctl_q[7:4])
        |=> !wctl_q[`PSWR_BIT_SETUP_VALID];
  endproperty
  a_ctrl_nibble: assert property (p_ctrl_nibble) else $error("valid kept on ctrl");

  property p_ctrl_read;
    @(posedge mclk) disable iff (!rstn)
      (rd && hit(addr, `PSWR_OFF_WAKE_CTRL)) |=> rdata[3:1] == 3'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl reserved set");

  property p_scratch_read_off;
    @(posedge mclk) disable iff (!rstn)
      (rd && !normal && hit(addr, `PSWR_OFF_SCRATCH)) |=> rdata == 8'h00;
  endproperty
  a_scratch_read_off: assert property (p_scratch_read_off) else $error("scratch read");

  property p_scratch_hold;
    @(posedge mclk) disable iff (!rstn)
      !(wr && normal && hit(addr, `PSWR_OFF_SCRATCH)) |=> $stable(scratch_q);
  endproperty
  a_scratch_hold: assert property (p_scratch_hold) else $error("scratch modified");

  property p_trim_ref;
    @(posedge mclk) disable iff (!rstn)
      !(wk.trim_mode && unlocked) |=> !trim_reference;
  endproperty
  a_trim_ref: assert property (p_trim_ref) else $error("trim while locked");

  property p_opt_write;
    @(posedge mclk) disable iff (!rstn)
      (wr && unlocked && hit(addr, `PSWR_OFF_LP_OPT) && !soft_rst)
        |=> opt_q == {7'h00, $past(wdata[0])};
  endproperty
  a_opt_write: assert property (p_opt_write) else $error("option lost");

  property p_irq_allow;
    @(posedge mclk) disable iff (!rstn)
      (wk.to_allow && stat_q[0] && mask_q[0]) |=> irq;
  endproperty
  a_irq_allow: assert property (p_irq_allow) else $error("timeout irq missing");

  property p_to_set;
    @(posedge mclk) disable iff (!rstn)
      (bus_timeout_event && selective_wakeup_en) |=> stat_q[0];
  endproperty
  a_to_set: assert property (p_to_set) else $error("timeout not flagged");

  property p_swk_needs_valid;
    @(posedge mclk) disable iff (!rstn)
      !wctl_q[`PSWR_BIT_SETUP_VALID] |=> !selective_wakeup_en;
  endproperty
  a_swk_needs_valid: assert property (p_swk_needs_valid) else $error("wake not valid");

  property p_ident_match;
    @(posedge mclk) disable iff (!rstn)
      (rx_ident_valid && rx_ident[28:21] == ident_q) |=> ident_high_match;
  endproperty
  a_ident_match: assert property (p_ident_match) else $error("ident match missing");
endmodule
`default_nettype wire

/* tb/pswr_host.sv */
// host microcontroller model driving the register port
`default_nettype none
module pswr_host (
  input wire logic mclk,
  output logic [6:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 7'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic put(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic get(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask
  // setup settled first, valid raised by a second write
  task automatic arm(input logic [7:0] c);
    put(7'h20, c & 8'hf0);
    put(7'h20, c | 8'h01);
  endtask
  function automatic logic [28:0] std_ident(input logic [10:0] s);
    return {s, 18'h00000};
  endfunction
endmodule
`default_nettype wire

/* tb/test_pswr_regs.sv */
// self-checking bench of the pwm / wake register bank
`default_nettype none
module test_pswr_regs import pswr_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, soft_rst, restart_entry, pin, tmo, wfs, idv;
  pswr_mode_t mode;
  logic [28:0] rxid;
  logic [6:0] addr, a;
  logic [7:0] wdata, rdata, q, qpb;
  logic [5:0] spf;
  logic wr, rd, irq, c1, c2, selective_wakeup, trim, tref, lpr, idm;
  int failures, check_count, n;
  int mdl [128];
  logic [31:0] rng;
  logic [6:0] ofs [7] = '{7'h1c, 7'h1e, 7'h21, 7'h22, 7'h23, 7'h7f, 7'h20};
  pswr_host host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  pswr_regs DUT (.mclk(mclk), .rstn(rstn), .soft_rst(soft_rst), .restart_entry(restart_entry),
    .chip_mode(mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .bus_transmit_input_pin(pin), .bus_timeout_event(tmo), .wake_frame_seen(wfs),
    .rx_ident(rxid), .rx_ident_valid(idv), .rdata(rdata), .irq(irq),
    .chan_one_rate_select(c1), .chan_two_rate_select(c2), .selective_wakeup_en(selective_wakeup),
    .oscillator_trim_mode(trim), .trim_reference(tref), .low_power_receiver_en(lpr),
    .quanta_per_bit(qpb), .sample_point_fraction(spf), .ident_high_match(idm));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic mreset(input bit keep);
    int s;
    s = mdl['h1e];
    foreach (mdl[i]) mdl[i] = 0;
    mdl['h21] = 'ha0;
    mdl['h22] = 'h33;
    if (keep) mdl['h1e] = s;
  endtask
  task automatic wr_m(input logic [6:0] wa, input logic [7:0] d);
    host.put(wa, d);
    case (wa)
      7'h1c: mdl[wa] = d & 8'h05;
      7'h1e, 7'h21, 7'h22, 7'h23: begin
        mdl[wa] = (wa == 7'h22) ? d & 8'h3f : d;
        if (wa != 7'h1e) mdl['h20] &= 'hf0;
      end
      7'h20: mdl[wa] = ((d ^ mdl[wa]) & 'hf0) ? d & 'hf0 : d & 'hf1;
      7'h30: if (mdl['h20][6:5] == 2'b11) mdl[wa] = d & 1;
      7'h32: mdl[wa] = d & 3;
      default: ;
    endcase
  endtask
  task automatic rd_c(input logic [6:0] ra);
    host.get(ra, q);
    chk($sformatf("reg %h", ra), q, mdl[ra][7:0]);
    if (ra == 7'h31) mdl['h31] = 0;
  endtask
  // 0 soft reset, 1 restart entry, 2 bus timeout, other wake frame
  task automatic pulse(input int sel);
    case (sel)
      0: soft_rst <= 1'b1;
      1: restart_entry <= 1'b1;
      2: tmo <= 1'b1;
      default: wfs <= 1'b1;
    endcase
    @(posedge mclk);
    {soft_rst, restart_entry, tmo, wfs} <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    wrap_up();
  end
  initial begin
    {rstn, soft_rst, restart_entry, pin, tmo, wfs, idv} = '0;
    mode = PSWR_MODE_NORMAL;
    rxid = '0;
    rng = 32'd98;
    failures = 0;
    check_count = 0;
    mreset(0);
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    foreach (ofs[i]) rd_c(ofs[i]);
    repeat (40) begin
      rng = xs(rng);
      a = ofs[rng[10:8] % 6];
      wr_m(a, rng[7:0]);
      rd_c(a);
    end
    repeat (2) @(posedge mclk);
    chk("rate one", c1, mdl['h1c][0]);
    chk("rate two", c2, mdl['h1c][2]);
    chk("quanta", qpb, mdl['h21][7:0]);
    chk("sample", spf, mdl['h22][5:0]);
    wr_m(7'h1e, 8'h5a);
    mode <= PSWR_MODE_STOP;
    host.put(7'h1e, 8'ha5);
    host.get(7'h1e, q);
    chk("scratch off normal", q, 8'h00);
    mode <= PSWR_MODE_NORMAL;
    wr_m(7'h20, 8'he0);
    pulse(0);
    mreset(1);
    foreach (ofs[i]) rd_c(ofs[i]);
    host.arm(8'hd0);
    mdl['h20] = 'hd1;
    mode <= PSWR_MODE_FAILSAFE;
    pulse(1);
    mode <= PSWR_MODE_NORMAL;
    mdl['h20] &= 'hf0;
    rd_c(7'h20);
    rd_c(7'h1e);
    wr_m(7'h20, 8'h00);
    wr_m(7'h30, 8'h01);
    rd_c(7'h30);
    wr_m(7'h20, 8'he0);
    pin <= 1'b1;
    wr_m(7'h30, 8'h01);
    repeat (3) @(posedge mclk);
    chk("low power rx", lpr, 1'b1);
    chk("trim mode", trim, 1'b1);
    chk("trim ref", tref, 1'b1);
    wr_m(7'h20, 8'ha0);
    repeat (3) @(posedge mclk);
    chk("trim ref locked", tref, 1'b0);
    wr_m(7'h32, 8'h01);
    host.arm(8'h10);
    mdl['h20] = 'h11;
    repeat (3) @(posedge mclk);
    chk("wake enable", selective_wakeup, 1'b1);
    pulse(2);
    mdl['h31] = 1;
    chk("irq", irq, 1'b1);
    rd_c(7'h31);
    repeat (3) @(posedge mclk);
    chk("irq cleared", irq, 1'b0);
    wr_m(7'h20, 8'h00);
    host.put(7'h20, 8'h01);
    // wake enable must stand before the timeout, or no flag is taken
    repeat (2) @(posedge mclk);
    pulse(2);
    mdl['h31] = 1;
    chk("irq masked", irq, 1'b0);
    rd_c(7'h31);
    pulse(3);
    mdl['h31] = 2;
    chk("wake after frame", selective_wakeup, 1'b0);
    pulse(2);
    rd_c(7'h31);
    wr_m(7'h23, 8'hb5);
    for (int k = 0; k < 2; k++) begin
      rxid <= host.std_ident({8'hb5 ^ 8'(k), 3'h2});
      idv <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("ident match", idm, k == 0);
      idv <= 1'b0;
      @(posedge mclk);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
